/* rtl/tlid_top.sv */
// tach / rotor-lock / identification clock driver for the shared output pin
//
// Chosen here: the register offsets and the Wishbone slave port.
`include "tlid_consts.svh"
module tlid_top #(
	parameter logic [31:0] IDENT_STEP_CYCLES = `TLID_IDENT_STEP_CYC
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire tlid_pkg::tlid_wb_req_t wb_req_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic regulators_ok_in,
	input wire tlid_pkg::tlid_cfg0_t nvm_cfg0_in,
	input wire tlid_pkg::tlid_cfg1_t nvm_cfg1_in,
	input wire logic nvm_valid_in,
	input wire logic speed_command_pin_in,
	input wire logic undervoltage_lockout_in,
	input wire logic [7:0] command_in,
	input wire tlid_pkg::tlid_phase_t motor_phase_in,
	input wire logic elec_pulse_in,
	input wire logic stall_in,
	output logic tach_lock_pin_out,
	output logic standby_out,
	output logic motor_on_req_out,
	output logic stall_flag_out
);
	import tlid_pkg::*;

	tlid_state_t st, nxt;
	logic tach_run;
	logic cmd_on;
	logic [27:0] id_inc;
	logic [31:0] id_limit;
	logic [12:0] tach_sum;
	logic [11:0] tach_thr;
	logic [31:0] wmask;

	always_comb begin
		nxt = st;
		cmd_on = command_in > st.cfg1.command_turn_on_threshold;
		case (st.cfg0.tach_start_select)
			2'h0: tach_run = motor_phase_in != TLID_PH_IDLE;
			2'h1: tach_run = motor_phase_in == TLID_PH_RAMP || motor_phase_in == TLID_PH_DRIVE;
			default: tach_run = motor_phase_in == TLID_PH_DRIVE;
		endcase
		id_inc = `TLID_IDENT_BASE_DHZ
			+ 28'(st.cfg1.ident_clock_freq_code) * `TLID_IDENT_INC_DHZ;
		id_limit = 32'({29'h0, st.cfg1.ident_duration_code} + 32'h1) * IDENT_STEP_CYCLES;
		tach_sum = 13'(st.tach_acc) + 13'(st.cfg0.tach_gain) + 13'h1;
		tach_thr = 12'({1'b0, st.cfg0.pole_pair_divider} + 4'h1) << `TLID_TACH_SHIFT;
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wb_req_in.wb_sel[i]}};
		end
		// synchronisers for pins
		nxt.reg_s1 = regulators_ok_in;
		nxt.reg_s2 = st.reg_s1;
		nxt.spd_s1 = speed_command_pin_in;
		nxt.spd_s2 = st.spd_s1;
		nxt.uv_s1 = undervoltage_lockout_in;
		nxt.uv_s2 = st.uv_s1;
		// power-up sequence
		case (st.fsm)
			TLID_PWR_WAIT: begin
				if (st.reg_s2) begin
					nxt.fsm = TLID_LOAD;
				end
			end
			TLID_LOAD: begin
				if (nvm_valid_in) begin
					nxt.cfg0 = nvm_cfg0_in;
					nxt.cfg1 = nvm_cfg1_in;
					nxt.fsm = TLID_STANDBY;
				end
			end
			default: nxt.fsm = TLID_STANDBY;
		endcase
		nxt.on_req = st.fsm == TLID_STANDBY && cmd_on;
		nxt.stall = stall_in;
		// identification pattern
		if (st.uv_s2) begin
			nxt.ident_act = 1'b0;
			nxt.ident_done = 1'b0;
		end else if (st.ident_act) begin
			nxt.id_cnt = st.id_cnt + 32'h1;
			if (st.id_acc + id_inc >= `TLID_IDENT_HALF_DHZ) begin
				nxt.id_acc = st.id_acc + id_inc - `TLID_IDENT_HALF_DHZ;
				nxt.id_clk = ~st.id_clk;
			end else begin
				nxt.id_acc = st.id_acc + id_inc;
			end
			if (st.id_cnt + 32'h1 >= id_limit || st.spd_s2 || cmd_on) begin
				nxt.ident_act = 1'b0;
				nxt.ident_done = 1'b1;
			end
		end else if (st.fsm == TLID_STANDBY && !st.ident_done) begin
			nxt.ident_done = 1'b1;
			if (st.cfg0.ident_pattern_enable && !st.spd_s2 && !cmd_on) begin
				nxt.ident_act = 1'b1;
				nxt.id_cnt = 32'h0;
				nxt.id_acc = 28'h0;
				nxt.id_clk = 1'b0;
				nxt.ident_done = 1'b0;
			end
		end
		// tach divider
		if (!st.cfg0.tach_output_enable || !tach_run) begin
			nxt.tach_acc = 12'h0;
		end else if (elec_pulse_in) begin
			if (tach_sum >= 13'(tach_thr)) begin
				nxt.tach_lvl = ~st.tach_lvl;
				nxt.tach_acc = (tach_sum - 13'(tach_thr) >= 13'(tach_thr)) ?
					tach_thr - 12'h1 : 12'(tach_sum - 13'(tach_thr));
			end else begin
				nxt.tach_acc = 12'(tach_sum);
			end
		end
		// pin priority
		if (st.uv_s2) begin
			nxt.pin = 1'b1;
		end else if (st.ident_act) begin
			nxt.pin = st.id_clk;
		end else if (st.cfg0.lock_output_enable && st.stall) begin
			nxt.pin = ~st.cfg0.lock_active_level;
		end else if (st.cfg0.tach_output_enable && tach_run) begin
			nxt.pin = st.tach_lvl;
		end else begin
			nxt.pin = 1'b1;
		end
		// wishbone slave, one wait state
		nxt.ack = wb_req_in.wb_cyc && wb_req_in.wb_stb && !st.ack;
		nxt.rdata = 32'h0;
		if (nxt.ack) begin
			if (wb_req_in.wb_adr == `TLID_ADR_CFG0) begin
				nxt.rdata = st.cfg0;
				if (wb_req_in.wb_we && st.fsm == TLID_STANDBY) begin
					nxt.cfg0 = (st.cfg0 & ~wmask) | (wb_req_in.wb_dat & wmask);
					nxt.cfg0.rsvd = '0;
				end
			end else if (wb_req_in.wb_adr == `TLID_ADR_CFG1) begin
				nxt.rdata = st.cfg1;
				if (wb_req_in.wb_we && st.fsm == TLID_STANDBY) begin
					nxt.cfg1 = (st.cfg1 & ~wmask) | (wb_req_in.wb_dat & wmask);
					nxt.cfg1.rsvd = '0;
				end
			end else if (wb_req_in.wb_adr == `TLID_ADR_STATUS) begin
				nxt.rdata = {22'h0, st.fsm, st.uv_s2, st.stall, st.ident_act,
					st.ident_done, st.on_req, st.tach_lvl, st.pin, st.spd_s2};
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '{fsm: TLID_PWR_WAIT, cfg0: `TLID_CFG0_RST, cfg1: `TLID_CFG1_RST,
				pin: 1'b1, default: '0};
		end else if (clk_en_in) begin
			st <= nxt;
		end
	end

	assign wb_dat_out = st.rdata;
	assign wb_ack_out = st.ack;
	assign tach_lock_pin_out = st.pin;
	assign standby_out = st.fsm == TLID_STANDBY;
	assign motor_on_req_out = st.on_req;
	assign stall_flag_out = st.stall;

	// checks
	sequence s_uv_seen;
		st.uv_s2 && clk_en_in;
	endsequence

	property p_uv_pin_high;
		@(posedge clock_in) disable iff (!rst_n_in)
		s_uv_seen |=> st.pin && !st.ident_act;
	endproperty
	a_uv_pin_high: assert property (p_uv_pin_high) else $error("pin not high in undervoltage");

	property p_cmd_gate;
		@(posedge clock_in) disable iff (!rst_n_in)
		st.fsm != TLID_STANDBY |-> !st.on_req || $past(st.fsm) == TLID_STANDBY;
	endproperty
	a_cmd_gate: assert property (p_cmd_gate) else $error("command accepted before standby");

	property p_on_threshold;
		@(posedge clock_in) disable iff (!rst_n_in)
		clk_en_in && st.fsm == TLID_STANDBY |=> st.on_req == $past(cmd_on);
	endproperty
	a_on_threshold: assert property (p_on_threshold) else $error("on request mismatch");

	property p_lock_level;
		@(posedge clock_in) disable iff (!rst_n_in)
		clk_en_in && !st.uv_s2 && !st.ident_act && st.cfg0.lock_output_enable && st.stall
		|=> st.pin == !$past(st.cfg0.lock_active_level);
	endproperty
	a_lock_level: assert property (p_lock_level) else $error("lock level wrong");

	property p_stall_follow;
		@(posedge clock_in) disable iff (!rst_n_in)
		clk_en_in && !stall_in |=> !st.stall;
	endproperty
	a_stall_follow: assert property (p_stall_follow) else $error("stall flag stuck");

	property p_spd_stops_ident;
		@(posedge clock_in) disable iff (!rst_n_in)
		clk_en_in && st.ident_act && st.spd_s2 |=> !st.ident_act;
	endproperty
	a_spd_stops_ident: assert property (p_spd_stops_ident) else $error("ident ran with pin high");

	sequence s_ident_end;
		$fell(st.ident_act) ##0 !st.uv_s2;
	endsequence

	property p_ident_once;
		@(posedge clock_in) disable iff (!rst_n_in)
		s_ident_end ##1 !st.uv_s2 |-> !st.ident_act;
	endproperty
	a_ident_once: assert property (p_ident_once) else $error("ident restarted");

	property p_ident_len;
		@(posedge clock_in) disable iff (!rst_n_in)
		st.ident_act |-> st.id_cnt < id_limit;
	endproperty
	a_ident_len: assert property (p_ident_len) else $error("ident overran duration");

	property p_ident_pin;
		@(posedge clock_in) disable iff (!rst_n_in)
		clk_en_in && st.ident_act && !st.uv_s2 |=> st.pin == $past(st.id_clk);
	endproperty
	a_ident_pin: assert property (p_ident_pin) else $error("ident not on pin");

	property p_tach_hold;
		@(posedge clock_in) disable iff (!rst_n_in)
		!tach_run |=> $stable(st.tach_lvl);
	endproperty
	a_tach_hold: assert property (p_tach_hold) else $error("tach moved before start");
endmodule // tlid_top

/* rtl/tlid_consts.svh */
// constants for the tach, lock and identification output block
`ifndef TLID_CONSTS_SVH
`define TLID_CONSTS_SVH
`define TLID_ADR_CFG0 8'h00
`define TLID_ADR_CFG1 8'h04
`define TLID_ADR_STATUS 8'h08
`define TLID_CLK_HZ 20000000
`define TLID_IDENT_STEP_MS 1125
`define TLID_IDENT_STEP_CYC (`TLID_IDENT_STEP_MS * (`TLID_CLK_HZ / 1000))
`define TLID_IDENT_BASE_DHZ 28'h0000a6b
`define TLID_IDENT_INC_DHZ 28'h0000059
`define TLID_IDENT_HALF_DHZ 28'h5f5e100
`define TLID_TACH_SHIFT 7
`define TLID_CFG0_RST 32'h00000000
`define TLID_CFG1_RST 32'h00000000
`endif

/* rtl/tlid_pkg.sv */
// types for the tach, lock and identification output block
package tlid_pkg;
	typedef enum logic [1:0] {TLID_PH_IDLE, TLID_PH_FOC, TLID_PH_RAMP, TLID_PH_DRIVE} tlid_phase_t;
	typedef enum logic [1:0] {TLID_PWR_WAIT, TLID_LOAD, TLID_STANDBY} tlid_fsm_t;
	typedef struct packed {
		logic [12:0] rsvd;
		logic tach_output_enable;
		logic lock_output_enable;
		logic lock_active_level;
		logic ident_pattern_enable;
		logic [1:0] tach_start_select;
		logic [2:0] pole_pair_divider;
		logic [9:0] tach_gain;
	} tlid_cfg0_t;
	typedef struct packed {
		logic [14:0] rsvd;
		logic [5:0] ident_clock_freq_code;
		logic [2:0] ident_duration_code;
		logic [7:0] command_turn_on_threshold;
	} tlid_cfg1_t;
	typedef struct packed {
		logic wb_cyc;
		logic wb_stb;
		logic wb_we;
		logic [7:0] wb_adr;
		logic [3:0] wb_sel;
		logic [31:0] wb_dat;
	} tlid_wb_req_t;
	typedef struct packed {
		tlid_fsm_t fsm;
		tlid_cfg0_t cfg0;
		tlid_cfg1_t cfg1;
		logic reg_s1, reg_s2, spd_s1, spd_s2, uv_s1, uv_s2;
		logic ident_act, ident_done, id_clk;
		logic [27:0] id_acc;
		logic [31:0] id_cnt;
		logic [11:0] tach_acc;
		logic tach_lvl, stall, on_req, pin, ack;
		logic [31:0] rdata;
	} tlid_state_t;
endpackage : tlid_pkg

/* dv/tlid_host_model.sv */
// fan host model: holds the speed pin and counts pin edges
module tlid_host_model (
	input wire logic clock_in,
	input wire logic tach_lock_pin_in,
	input wire logic hold_low_in,
	output logic speed_command_pin_out,
	output logic [15:0] edge_count_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_r;
	initial begin
		edge_count_out = 16'h0000;
		last_r = 1'b1;
	end
	assign speed_command_pin_out = !hold_low_in;
	always @(posedge clock_in) begin
		if (tach_lock_pin_in !== last_r) edge_count_out <= edge_count_out + 16'h0001;
		last_r <= tach_lock_pin_in;
	end
endmodule // tlid_host_model

/* dv/tlid_tb_top.sv */
// self-checking bench for the shared tach/lock pin driver
`include "tlid_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module tlid_tb_top;
	import tlid_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic reg_ok = 1'b0, nvm_valid = 1'b0, uv = 1'b0, hold_low = 1'b1;
	logic elec_pulse = 1'b0, stall = 1'b0, spd_pin, ack, pin, standby, on_req, stall_flag;
	logic [7:0] command = 8'h00;
	logic clk_en = 1'b1;
	tlid_phase_t phase = TLID_PH_DRIVE;
	logic [31:0] rdat, rd;
	logic [15:0] edges, base;
	tlid_wb_req_t wb_req = '0;
	tlid_cfg0_t cfg0 = 32'h00008000;
	int fail_count = 0, n_compared = 0, cyc_count = 0;
	logic [9:0] gains [3] = '{10'h07f, 10'h07f, 10'h03f};
	logic [2:0] divs [3] = '{3'h0, 3'h1, 3'h0};
	always #25 clock_in = ~clock_in;
	tlid_top #(.IDENT_STEP_CYCLES(32'h000000c8)) dut (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .clk_en_in(clk_en), .wb_req_in(wb_req), .wb_dat_out(rdat),
		.wb_ack_out(ack), .regulators_ok_in(reg_ok), .nvm_cfg0_in(cfg0),
		.nvm_cfg1_in(32'h00000000), .nvm_valid_in(nvm_valid),
		.speed_command_pin_in(spd_pin), .undervoltage_lockout_in(uv),
		.command_in(command), .motor_phase_in(phase),
		.elec_pulse_in(elec_pulse), .stall_in(stall), .tach_lock_pin_out(pin),
		.standby_out(standby), .motor_on_req_out(on_req), .stall_flag_out(stall_flag));
	tlid_host_model host (.clock_in(clock_in), .tach_lock_pin_in(pin),
		.hold_low_in(hold_low), .speed_command_pin_out(spd_pin), .edge_count_out(edges));
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		wb_req <= {1'b1, 1'b1, we, adr, 4'hf, d};
		@(posedge clock_in);
		while (ack !== 1'b1) @(posedge clock_in);
		rd = rdat;
		wb_req <= '0;
		@(posedge clock_in);
	endtask
	task automatic pulses();
		repeat (16) begin
			elec_pulse <= 1'b1;
			@(posedge clock_in);
			elec_pulse <= 1'b0;
			wait_cyc(7);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge clock_in) begin
		cyc_count++;
		if (cyc_count == 5000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		wait_cyc(16);
		`CHK("pin in reset", 1'b1, pin)
		rst_n_in <= 1'b1;
		wait_cyc(8);
		`CHK("standby before regulators", 1'b0, standby)
		reg_ok <= 1'b1;
		wait_cyc(8);
		`CHK("standby before nvm", 1'b0, standby)
		nvm_valid <= 1'b1;
		wait_cyc(4);
		`CHK("standby", 1'b1, standby)
		wb(1'b0, `TLID_ADR_STATUS, 32'h0);
		`CHK("ident active", 1'b1, rd[5])
		`CHK("pin during ident", 1'b0, pin)
		wait_cyc(200);
		wb(1'b0, `TLID_ADR_STATUS, 32'h0);
		`CHK("ident done", 2'b01, rd[5:4])
		`CHK("pin after ident", 1'b1, pin)
		$display("test ident finished");
		uv <= 1'b1;
		wait_cyc(5);
		`CHK("pin in uv", 1'b1, pin)
		wb(1'b0, `TLID_ADR_STATUS, 32'h0);
		`CHK("ident stopped in uv", 1'b0, rd[5])
		uv <= 1'b0;
		wait_cyc(6);
		wb(1'b0, `TLID_ADR_STATUS, 32'h0);
		`CHK("ident restarted", 1'b1, rd[5])
		hold_low <= 1'b0;
		wait_cyc(5);
		wb(1'b0, `TLID_ADR_STATUS, 32'h0);
		`CHK("ident ended by speed pin", 1'b0, rd[5])
		$display("test uv finished");
		wb(1'b1, `TLID_ADR_CFG0, 32'h00030000);
		stall <= 1'b1;
		wait_cyc(20);
		`CHK("lock level one", 1'b0, pin)
		`CHK("stall flag", 1'b1, stall_flag)
		wb(1'b1, `TLID_ADR_CFG0, 32'h00020000);
		wait_cyc(3);
		`CHK("lock level zero", 1'b1, pin)
		stall <= 1'b0;
		wait_cyc(3);
		`CHK("stall cleared", 1'b0, stall_flag)
		$display("test lock finished");
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, `TLID_ADR_CFG0, {13'h0, 6'h20, divs[i], gains[i]});
			wait_cyc(4);
			base = edges;
			pulses();
			`CHK("tach edges", 16'(16 / (divs[i] + 1) / (128 / (gains[i] + 1))), edges - base)
		end
		clk_en <= 1'b0;
		wait_cyc(2);
		base = edges;
		pulses();
		`CHK("tach frozen by clock enable", 16'h0000, edges - base)
		clk_en <= 1'b1;
		phase <= TLID_PH_RAMP;
		wb(1'b1, `TLID_ADR_CFG0, {13'h0, 6'h22, 3'h0, 10'h07f});
		wait_cyc(4);
		base = edges;
		pulses();
		`CHK("tach held before drive", 16'h0000, edges - base)
		wb(1'b1, `TLID_ADR_CFG0, {13'h0, 6'h21, 3'h0, 10'h07f});
		wait_cyc(4);
		base = edges;
		pulses();
		`CHK("tach during ramp", 16'h0010, edges - base)
		phase <= TLID_PH_DRIVE;
		$display("test tach finished");
		wb(1'b1, `TLID_ADR_CFG1, 32'h00000040);
		command <= 8'h40;
		wait_cyc(3);
		`CHK("on request at threshold", 1'b0, on_req)
		command <= 8'h41;
		wait_cyc(3);
		`CHK("on request above", 1'b1, on_req)
		wb(1'b0, 8'hfc, 32'h0);
		`CHK("unmapped read", 32'h00000000, rd)
		$display("test command finished");
		tally_and_finish();
	end
endmodule // tlid_tb_top
